// ==== core/drive_run_sequencer.v ====
// Run, jog and direction sequencing for a motor drive, with APB registers
// Assumes pin inputs are asynchronous; drive state feedback comes from the same clock
//
// Local design decisions: the placing of the registers and register access over APB.
`include "seq_consts.vh"
module drive_run_sequencer #(
	parameter BOTH_DELAY_CYC = `BOTH_DELAY_CYC
)(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        run_permit,
	input  wire [3:0]  seq_in,
	input  wire        key_run,
	input  wire        key_stop,
	input  wire        key_dir,
	output reg         run_cmd,
	output reg         jog_cmd,
	output reg         reverse_cmd
);
	reg [31:0] ctrl_r;
	reg [4:0]  s1_r;
	reg [4:0]  s2_r;
	reg [2:0]  k1_r;
	reg [2:0]  k2_r;
	reg [2:0]  kp_r;
	reg [2:0]  kpulse_r;
	reg [3:0]  sp_r;
	reg        dir_r;
	reg        latch_r;
	reg [31:0] dly_r;
	reg        both_stop_r;
	reg        run_nxt;
	reg        jog_nxt;
	reg        rev_nxt;
	reg        latch_nxt;
	reg        dir_nxt;
	reg [31:0] dly_nxt;
	reg        both_nxt;

	// Sequencing mode codes
	localparam [2:0] MODE_LATCH = 3'h0;
	localparam [2:0] MODE_PAIR  = 3'h1;
	localparam [2:0] MODE_WIRE  = 3'h2;
	localparam [2:0] MODE_LEVEL = 3'h3;
	localparam [2:0] MODE_PROOF = 3'h4;

	wire [2:0] mode = ctrl_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
	wire       permit = s2_r[4];
	wire [3:0] sq = s2_r[3:0];
	wire [3:0] srise = sq & ~sp_r;
	wire       idle = ~run_cmd & ~jog_cmd;
	wire       wr = psel & penable & pwrite;
	wire       both = sq[0] & sq[2];
	// Both-held delay applies in mode 2 and in open-loop mode 4 only;
	// closed-loop mode 4 stops as soon as both directions are seen
	wire       both_dly = (mode == MODE_WIRE) |
		((mode == MODE_PROOF) & ctrl_r[`CTRL_OPEN_LOOP]);

	// Zero-wait slave; answers come from flops like every other output
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b1;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= 1'b1;
			pslverr <= 1'b0;
		end
	end

	// Bus slave: zero-wait, unmapped reads return zero
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_r <= `CTRL_RESET_VAL;
		else if (wr && paddr == `ADDR_CTRL)
		begin
			ctrl_r <= {25'h0, pwdata[6:0]};
			if (pwdata[2:0] > 3'h4)
				ctrl_r[2:0] <= `MODE_RESET;
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
		begin
			case (paddr)
				`ADDR_CTRL:   prdata <= ctrl_r;
				`ADDR_KEYPAD: prdata <= {29'h0, k2_r};
				`ADDR_STATUS: prdata <= {26'h0, both_stop_r, latch_r, dir_r,
					reverse_cmd, jog_cmd, run_cmd};
				default:      prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Input synchronisers and edge history
	// Only the second stage feeds logic; edge history resets to the
	// released level so no false run pulse follows reset
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_r <= 5'h00;
			s2_r <= 5'h00;
			k1_r <= 3'h0;
			k2_r <= 3'h0;
			kp_r <= 3'h0;
			kpulse_r <= 3'h0;
			sp_r <= 4'h0;
		end
		else
		begin
			s1_r <= {run_permit, seq_in};
			s2_r <= s1_r;
			k1_r <= {key_dir, key_stop, key_run};
			k2_r <= k1_r;
			kp_r <= k2_r;
			kpulse_r <= k2_r & ~kp_r;
			sp_r <= sq;
		end
	end

	// Sequencing decision
	always @*
	begin
		run_nxt = 1'b0;
		jog_nxt = 1'b0;
		rev_nxt = dir_r;
		latch_nxt = latch_r;
		dir_nxt = dir_r;
		dly_nxt = 32'h0;
		both_nxt = 1'b0;
		case (mode)
			MODE_LATCH:
			begin
				// Terminal or keypad run pulses latch, as CTRL_KEY_RUN_EN picks; permit drop clears
				if (ctrl_r[`CTRL_KEY_DIR_EN])
				begin
					if (kpulse_r[`KEY_DIR_BIT])
						dir_nxt = ~dir_r;
				end
				else
					dir_nxt = sq[2];
				if (!permit)
					latch_nxt = 1'b0;
				else if (ctrl_r[`CTRL_KEY_STOP_EN] && kpulse_r[`KEY_STOP_BIT])
					latch_nxt = 1'b0;
				else if (ctrl_r[`CTRL_KEY_RUN_EN] ? kpulse_r[`KEY_RUN_BIT] : srise[0])
					latch_nxt = 1'b1;
				run_nxt = latch_nxt;
				jog_nxt = permit & ~latch_nxt & sq[1] & (idle | jog_cmd);
				rev_nxt = dir_nxt;
			end
			MODE_PAIR:
			begin
				// Terminal run edges beat keypad; held run terminals (sq[0], sq[2]) lock keypad stop and direction
				if (!permit)
					latch_nxt = 1'b0;
				else if (srise[0] | srise[2])
				begin
					latch_nxt = 1'b1;
					dir_nxt = srise[2] & ~srise[0];
				end
				else if (ctrl_r[`CTRL_KEY_DIR_EN] && kpulse_r[`KEY_DIR_BIT]
					&& !sq[0] && !sq[2])
					dir_nxt = ~dir_r;
				else if (ctrl_r[`CTRL_KEY_RUN_EN] && kpulse_r[`KEY_RUN_BIT])
					latch_nxt = 1'b1;
				else if (ctrl_r[`CTRL_KEY_STOP_EN] && kpulse_r[`KEY_STOP_BIT]
					&& !sq[0] && !sq[2])
					latch_nxt = 1'b0;
				run_nxt = latch_nxt;
				if (permit && !latch_nxt && (sq[1] ^ sq[3]) && (idle | jog_cmd))
				begin
					jog_nxt = 1'b1;
					dir_nxt = sq[3];
				end
				rev_nxt = dir_nxt;
			end
			MODE_WIRE, MODE_PROOF:
			begin
				// keypad inputs take no part here
				// Delay count saturates so the stop stays asserted while held
				if (both && both_dly)
				begin
					dly_nxt = (dly_r < BOTH_DELAY_CYC) ? dly_r + 32'h1 : dly_r;
					both_nxt = (dly_r >= BOTH_DELAY_CYC - 1);
				end
				// delay restarts whenever both are not held
				if ((mode == 3'h4 || permit) && (sq[0] ^ sq[2]))
				begin
					if (sq[1] && (idle | jog_cmd))
						jog_nxt = 1'b1;
					else if (!jog_cmd || !sq[1])
						run_nxt = 1'b1;
					dir_nxt = sq[2];
				end
				else if (both && !both_nxt && both_dly)
				begin
					run_nxt = run_cmd & permit_ok(mode, permit);
					jog_nxt = jog_cmd & permit_ok(mode, permit);
				end
				rev_nxt = dir_nxt;
			end
			MODE_LEVEL:
			begin
				// Jog must be held first; a running drive ignores a late jog
				// permit ignored, levels followed directly
				dir_nxt = sq[2];
				if (sq[0] && sq[1] && (idle | jog_cmd))
					jog_nxt = 1'b1;
				else if (sq[0] && !jog_cmd)
					run_nxt = 1'b1;
				else if (sq[0] && !sq[1])
					run_nxt = 1'b1;
				rev_nxt = dir_nxt;
			end
			default:
			begin
				latch_nxt = 1'b0;
			end
		endcase
		// Level-held modes never keep a latch across a mode change
		if (mode != MODE_LATCH && mode != MODE_PAIR)
			latch_nxt = 1'b0;
	end

	// Mode 4 runs without permit; mode 2 needs it
	function permit_ok;
		input [2:0] m;
		input       p;
		begin
			permit_ok = (m == 3'h4) | p;
		end
	endfunction

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_cmd <= 1'b0;
			jog_cmd <= 1'b0;
			reverse_cmd <= 1'b0;
			latch_r <= 1'b0;
			dir_r <= 1'b0;
			dly_r <= 32'h0;
			both_stop_r <= 1'b0;
		end
		else
		begin
			run_cmd <= run_nxt;
			jog_cmd <= jog_nxt;
			reverse_cmd <= rev_nxt;
			latch_r <= latch_nxt;
			dir_r <= dir_nxt;
			dly_r <= dly_nxt;
			both_stop_r <= both_nxt;
		end
	end
endmodule

// ==== core/seq_consts.vh ====
// Constants for the drive run sequencer
// Assumes inclusion by bare name from the core design file
`ifndef SEQ_CONSTS_VH
`define SEQ_CONSTS_VH
`define ADDR_CTRL        12'h000
`define ADDR_KEYPAD      12'h004
`define ADDR_STATUS      12'h008
`define CTRL_MODE_LSB    0
`define CTRL_MODE_MSB    2
`define CTRL_OPEN_LOOP   3
`define CTRL_KEY_RUN_EN  4
`define CTRL_KEY_STOP_EN 5
`define CTRL_KEY_DIR_EN  6
`define CTRL_RESET_VAL   32'h0000_0004
`define MODE_RESET       3'h4
`define KEY_RUN_BIT      0
`define KEY_STOP_BIT     1
`define KEY_DIR_BIT      2
`define BOTH_DELAY_MS    60
`define CLK_HZ           25000000
`define BOTH_DELAY_CYC   ((`CLK_HZ / 1000) * `BOTH_DELAY_MS)
`endif

// ==== test/contact_panel.sv ====
// Contacts, PLC outputs and keypad buttons at the sequencer pins
// Assumes the bench asks for new levels just after a clock edge
module contact_panel (
	input  wire logic       pclk,
	input  wire logic [7:0] set_v,
	output logic      [7:0] pin_v = 8'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge pclk) pin_v <= set_v;
endmodule

// ==== test/drive_run_sequencer_bench.sv ====
// Self-checking bench for the run sequencer over APB and its pins
// Assumes outputs settle within six edges of a contact change
module drive_run_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int D = 20;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [7:0]  set_v = 8'h00, pin_v;
	logic        run_cmd, jog_cmd, reverse_cmd, pslverr;
	int          error_cnt = 0, comparisons = 0, cyc = 0;
	always #20 pclk = ~pclk;
	contact_panel pan_u (.pclk, .set_v, .pin_v);
	drive_run_sequencer #(.BOTH_DELAY_CYC(D)) dut_u (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .run_permit(pin_v[4]),
		.seq_in(pin_v[3:0]), .key_run(pin_v[5]), .key_stop(pin_v[6]), .key_dir(pin_v[7]),
		.run_cmd, .jog_cmd, .reverse_cmd);
	task chk(string n, logic [31:0] s, e);
		comparisons++;
		if (s !== e)
		begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	task xfer(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task pin(logic [7:0] v, int n);
		set_v <= v;
		repeat (n) @(posedge pclk);
	endtask
	task stop_test;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			error_cnt++;
			stop_test;
		end
	end
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		xfer(0, 12'h000, 0);
		chk("ctrl", rd, 32'h4);
		chk("pslverr", pslverr, 0);
		for (int i = 0; i < 6; i++)
		begin
			xfer(1, 12'h000, i);
			xfer(0, 12'h000, 0);
			chk("mode", rd, (i > 4) ? 4 : i);
		end
		xfer(0, 12'h00C, 0);
		chk("unmapped", rd, 0);
		pin(8'h01, 6);
		chk("m4 run", {run_cmd, reverse_cmd}, 2'h2);
		pin(8'h00, 6);
		chk("m4 stop", run_cmd, 0);
		pin(8'h02, 3);
		pin(8'h06, 6);
		chk("m4 jog", {jog_cmd, reverse_cmd}, 2'h3);
		pin(8'h00, 6);
		xfer(1, 12'h000, 3);
		pin(8'h05, 6);
		chk("m3 run", {run_cmd, reverse_cmd}, 2'h3);
		pin(8'h00, 6);
		xfer(1, 12'h000, 32'h72);
		pin(8'h30, 6);
		chk("m2 key", run_cmd, 0);
		pin(8'h11, 6);
		pin(8'h15, 5);
		pin(8'h11, D + 6);
		chk("m2 cancel", run_cmd, 1);
		pin(8'h15, D - 2);
		chk("m2 delay", run_cmd, 1);
		pin(8'h15, 12);
		chk("m2 both", run_cmd, 0);
		pin(8'h00, 6);
		xfer(1, 12'h000, 32'h10);
		pin(8'h11, 6);
		chk("m0 term", run_cmd, 0);
		pin(8'h30, 6);
		pin(8'h10, 6);
		chk("m0 latch", run_cmd, 1);
		pin(8'h00, 6);
		chk("m0 permit", run_cmd, 0);
		xfer(1, 12'h000, 32'h21);
		pin(8'h11, 6);
		pin(8'h14, 6);
		pin(8'h10, 6);
		chk("m1 rev", {run_cmd, reverse_cmd}, 2'h3);
		pin(8'h50, 6);
		chk("m1 stop", run_cmd, 0);
		pin(8'h18, 6);
		chk("m1 jog", {jog_cmd, reverse_cmd}, 2'h3);
		pin(8'h10, 6);
		xfer(1, 12'h000, 32'h0);
		pin(8'h12, 6);
		chk("m0 jog", {run_cmd, jog_cmd}, 2'h1);
		pin(8'h13, 6);
		chk("m0 run over jog", {run_cmd, jog_cmd}, 2'h2);
		pin(8'h00, 6);
		xfer(1, 12'h000, 32'h41);
		pin(8'h11, 6);
		pin(8'h10, 6);
		pin(8'h90, 6);
		chk("m1 key dir", {run_cmd, reverse_cmd}, 2'h3);
		pin(8'h00, 6);
		xfer(1, 12'h000, 32'h0C);
		pin(8'h01, 6);
		pin(8'h05, D - 2);
		chk("m4 ol delay", run_cmd, 1);
		pin(8'h05, 12);
		chk("m4 ol both", run_cmd, 0);
		xfer(0, 12'h008, 0);
		chk("status", rd, 32'h20);
		xfer(1, 12'h000, 32'h04);
		pin(8'h01, 6);
		pin(8'h05, 6);
		chk("m4 cl both", run_cmd, 0);
		pin(8'h00, 6);
		xfer(1, 12'h000, 32'h02);
		pin(8'h12, 3);
		pin(8'h13, 6);
		chk("m2 jog", {run_cmd, jog_cmd}, 2'h1);
		pin(8'hE0, 6);
		xfer(0, 12'h004, 0);
		chk("keypad", rd, 32'h7);
		pin(8'h11, 6);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		chk("reset out", {run_cmd, jog_cmd, reverse_cmd}, 3'h0);
		presetn <= 1'h1;
		xfer(0, 12'h000, 0);
		chk("reset mode", rd, 32'h4);
		pin(8'h01, 6);
		chk("reset m4 run", run_cmd, 1);
		stop_test;
	end
endmodule

// ==== test/drive_run_sequencer_properties.sv ====
// Checker on the sequencer ports; mode tracked from APB writes
// Assumes outputs follow a pin change within three edges
module seq_checker (
	input wire logic        pclk, presetn, psel, penable, pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        run_permit,
	input wire logic [3:0]  seq_in,
	input wire logic        run_cmd, jog_cmd, reverse_cmd
);
	logic [2:0] m;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			m <= 3'h4;
		else if (psel && penable && pwrite && paddr == 12'h000)
			m <= (pwdata[2:0] > 3'h4) ? 3'h4 : pwdata[2:0];
	property p_perm; (m < 3'h2 && !run_permit)[*4] |-> !run_cmd; endproperty
	a_perm: assert property (p_perm) else $error("run no permit");
	property p_wp; (m == 3'h2 && !run_permit)[*4] |-> !run_cmd; endproperty
	a_wp: assert property (p_wp) else $error("m2 no permit");
	property p_fwd; (m == 3'h2 && run_permit && seq_in == 4'h1)[*4] |-> run_cmd; endproperty
	a_fwd: assert property (p_fwd) else $error("m2 fwd");
	property p_idle; (m > 3'h1 && seq_in == 4'h0)[*4] |-> !run_cmd && !jog_cmd; endproperty
	a_idle: assert property (p_idle) else $error("idle run");
	property p_lvl; (m == 3'h3 && seq_in == 4'h5)[*4] |-> run_cmd && reverse_cmd; endproperty
	a_lvl: assert property (p_lvl) else $error("m3 level");
	property p_off; (m == 3'h3 && seq_in[1:0] == 2'h0)[*4] |-> !run_cmd; endproperty
	a_off: assert property (p_off) else $error("m3 off");
	property p_m4; (m == 3'h4 && seq_in == 4'h1)[*4] |-> run_cmd && !reverse_cmd; endproperty
	a_m4: assert property (p_m4) else $error("m4 fwd");
	property p_jog; $rose(jog_cmd) |-> !$past(run_cmd); endproperty
	a_jog: assert property (p_jog) else $error("jog busy");
endmodule
bind drive_run_sequencer seq_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .run_permit, .seq_in, .run_cmd, .jog_cmd, .reverse_cmd);
